/* File: src/cws_dev.sv */
// Slave end: communication monitor, communication watchdog and safety code
// word generator. Assumes requests are one-cycle pulses already validated by
// the receiver, and configuration flags held steady by the nonvolatile store.
`timescale 1ns/100ps
`default_nettype none
module cws_dev
  import cws_pkg::*;
#(
  parameter int unsigned MON_CYCLES = MON_TIMEOUT_CYCLES,
  parameter int unsigned HOLD_CYC = HOLD_CYCLES,
  parameter int unsigned STB_CYCLES = STROBE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link
  cws_if.dev lnk,
  // Configuration flags
  input wire logic program_lock_flag,
  input wire logic inhibit_flag,
  input wire logic param_bit_wd_enable_flag,
  input wire logic safety_enable,
  input wire logic safe_on_param,
  input wire logic [ADDR_W-1:0] slave_address,
  input wire logic nvm_write_busy,
  input wire logic address_delete,
  input wire logic [TABLE_DEPTH*ENTRY_W-1:0] code_table,
  // Optional modes requested by the profile
  input wire logic delay_mode_req,
  input wire logic sync_io_req,
  input wire logic ext_4io_req,
  output logic delay_mode_en,
  output logic sync_io_en,
  output logic ext_4io_en,
  // Ports
  input wire logic [DATA_W-1:0] port_inputs,
  output logic [DATA_W-1:0] data_port,
  output logic [DATA_W-1:0] param_port,
  // Status
  output logic red_status_indicator,
  output logic exchange_disable,
  output logic watchdog_enable,
  output logic safety_active
);
  localparam int MW = $clog2(MON_CYCLES + 1);
  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam int SW = $clog2(STB_CYCLES + 1);
  if (MON_CYCLES < 2 || HOLD_CYC < 1 || STB_CYCLES < 1) begin : g_chk
    $error("Interval parameters too small");
  end
  cws_wd_state_t wd_state;
  logic [MW-1:0] gap_cnt;
  logic gap_expired;
  logic mon_active;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] param_out;
  logic [SW-1:0] dstb_cnt;
  logic [SW-1:0] pstb_cnt;
  logic [IDX_W-1:0] code_idx;
  logic [HW-1:0] hold_cnt;
  logic any_request;
  logic wd_fire;
  logic wd_init;
  logic exch_ok;
  logic advance;
  logic [IDX_W-1:0] next_idx;
  logic [ENTRY_W-1:0] cur_entry;
  logic [ENTRY_W-1:0] ans_entry;
  logic [DATA_W-1:0] safe_word;
  // Enable table
  function automatic logic wd_en(input logic lock, input logic inhibit,
                                 input logic bit_flag, input logic safety,
                                 input logic bit_reg);
    return lock && !inhibit && (!bit_flag || safety || bit_reg);
  endfunction
  function automatic logic [ENTRY_W-1:0] entry_at(input logic [IDX_W-1:0] i,
                                                  input logic [TABLE_DEPTH*ENTRY_W-1:0] t);
    return t[i*ENTRY_W +: ENTRY_W];
  endfunction
  assign safety_active = safety_enable;
  assign delay_mode_en = delay_mode_req & ~safety_enable;
  assign sync_io_en = sync_io_req & ~safety_enable;
  assign ext_4io_en = ext_4io_req & ~safety_enable;
  // Only the written register counts, so pins mapped as inputs cannot steer it
  assign watchdog_enable = wd_en(program_lock_flag, inhibit_flag,
                                 param_bit_wd_enable_flag, safety_enable,
                                 param_out[0]);
  assign any_request = lnk.exchange_request | lnk.param_write_request;
  assign gap_expired = (gap_cnt == MW'(MON_CYCLES));
  assign wd_fire = (wd_state == WD_IDLE) && watchdog_enable && gap_expired &&
                   (slave_address != '0) && !nvm_write_busy;
  assign wd_init = (wd_state == WD_INIT);
  assign exch_ok = lnk.exchange_request && !exchange_disable && (wd_state == WD_IDLE);
  // Gap timer; init restarts it so a dead link re-fires only after a full gap
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gap_cnt <= '0;
    end else if (any_request || wd_init) begin
      gap_cnt <= '0;
    end else if (!gap_expired) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end
  // Arming wins over a deletion landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst || wd_init) begin
      mon_active <= 1'b0;
    end else if (lnk.param_write_request && slave_address != '0) begin
      mon_active <= 1'b1;
    end else if (address_delete) begin
      mon_active <= 1'b0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      red_status_indicator <= 1'b0;
    end else begin
      red_status_indicator <= mon_active && gap_expired && !any_request;
    end
  end
  // Watchdog sequence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wd_state <= WD_IDLE;
    end else begin
      case (wd_state)
        WD_IDLE: begin
          if (wd_fire) begin
            wd_state <= WD_STROBE;
          end
        end
        WD_STROBE: begin
          if (dstb_cnt == '0 && pstb_cnt == '0) begin
            wd_state <= WD_RESET;
          end
        end
        WD_RESET: wd_state <= WD_INIT;
        WD_INIT: wd_state <= WD_IDLE;
        default: wd_state <= WD_IDLE;
      endcase
    end
  end
  // Set wins over a parameter write landing in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exchange_disable <= 1'b0;
    end else if (wd_state == WD_RESET) begin
      exchange_disable <= 1'b1;
    end else if (lnk.param_write_request) begin
      exchange_disable <= 1'b0;
    end
  end
  // Strobes: normal ones per request, both together on a watchdog hit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dstb_cnt <= '0;
      pstb_cnt <= '0;
    end else begin
      if (wd_fire || exch_ok) begin
        dstb_cnt <= SW'(STB_CYCLES);
      end else if (dstb_cnt != '0) begin
        dstb_cnt <= dstb_cnt - 1'b1;
      end
      if (wd_fire || (lnk.param_write_request && wd_state == WD_IDLE)) begin
        pstb_cnt <= SW'(STB_CYCLES);
      end else if (pstb_cnt != '0) begin
        pstb_cnt <= pstb_cnt - 1'b1;
      end
    end
  end
  assign lnk.data_strobe_n = (dstb_cnt == '0);
  assign lnk.param_strobe_n = (pstb_cnt == '0);
  // Output registers hold last request values until init
  always_ff @(posedge sys_clk) begin
    if (rst || wd_init) begin
      data_out <= PORT_INACTIVE;
      param_out <= PORT_INACTIVE;
    end else if (wd_state == WD_IDLE) begin
      if (exch_ok) begin
        data_out <= lnk.exch_data;
      end
      if (lnk.param_write_request) begin
        param_out <= lnk.param_data;
      end
    end
  end
  // Code word position and its hold window
  assign advance = exch_ok && safety_enable && (hold_cnt == '0);
  assign next_idx = code_idx + 1'b1;
  assign cur_entry = entry_at(code_idx, code_table);
  assign ans_entry = advance ? entry_at(next_idx, code_table) : cur_entry;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      code_idx <= '0;
      hold_cnt <= '0;
    end else if (advance) begin
      code_idx <= next_idx;
      hold_cnt <= HW'(HOLD_CYC);
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
    end
  end
  // Transmitted word: returned loop bits plus stored bits gated by offsets
  always_comb begin
    safe_word = '0;
    safe_word[0] = lnk.safe_input_a;
    safe_word[2] = lnk.safe_input_b;
    safe_word[1] = lnk.safe_offset_a &
                   (ans_entry[E_SWAP] ? ans_entry[E_BIT3] : ans_entry[E_BIT1]);
    safe_word[3] = lnk.safe_offset_b &
                   (ans_entry[E_SWAP] ? ans_entry[E_BIT1] : ans_entry[E_BIT3]);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lnk.answer_valid <= 1'b0;
      lnk.answer_data <= PORT_INACTIVE;
    end else begin
      lnk.answer_valid <= exch_ok || (lnk.param_write_request && wd_state == WD_IDLE);
      if (exch_ok) begin
        lnk.answer_data <= safety_enable ? safe_word : port_inputs;
      end else if (lnk.param_write_request) begin
        lnk.answer_data <= lnk.param_data;
      end
    end
  end

  // Pins: safety drive replaces bits one and three of the selected port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      data_port <= PORT_INACTIVE;
      param_port <= PORT_INACTIVE;
      lnk.safe_drive_a <= 1'b0;
      lnk.safe_drive_b <= 1'b0;
    end else begin
      lnk.safe_drive_a <= safety_enable & cur_entry[E_BIT0];
      lnk.safe_drive_b <= safety_enable & cur_entry[E_BIT2];
      data_port <= data_out;
      param_port <= param_out;
      if (safety_enable && !safe_on_param) begin
        data_port[1] <= cur_entry[E_BIT0];
        data_port[3] <= cur_entry[E_BIT2];
      end else if (safety_enable) begin
        param_port[1] <= cur_entry[E_BIT0];
        param_port[3] <= cur_entry[E_BIT2];
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/cws_host.sv */
// Far end: bus master request source, code table programmer and the outside
// safety circuit that inverts, offsets and delays the safety drive bits.
// Assumes user commands are one-cycle pulses synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module cws_host
  import cws_pkg::*;
#(
  parameter int unsigned LOOP_DELAY = SAFE_DELAY_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link
  cws_if.host lnk,
  // Master commands
  input wire logic cmd_exchange,
  input wire logic cmd_param,
  input wire logic [DATA_W-1:0] cmd_exch_data,
  input wire logic [DATA_W-1:0] cmd_param_data,
  output logic [DATA_W-1:0] reply_data,
  output logic reply_valid,
  // Safety switches, high when closed
  input wire logic switch_a,
  input wire logic switch_b,
  // Table programming
  input wire logic [TABLE_DEPTH*DATA_W-1:0] ref_table,
  input wire logic [TABLE_DEPTH-1:0] swap_mask,
  output logic [TABLE_DEPTH*ENTRY_W-1:0] coded_table,
  output logic table_ok
);
  localparam int DW = $clog2(LOOP_DELAY + 1);

  if (LOOP_DELAY < 1) begin : g_chk
    $error("LOOP_DELAY must be at least one cycle");
  end

  logic [DATA_W-1:0] last_param;
  logic rewrite_pending;
  logic [3:0] gap_cnt;
  logic both_low_seen;
  logic [DW-1:0] dly_cnt;
  logic [1:0] drive_snap;
  logic [1:0] loop_level;

  // Encoding of one entry from the reference table
  function automatic logic [ENTRY_W-1:0] encode(input logic [DATA_W-1:0] cur,
                                                input logic [DATA_W-1:0] nxt,
                                                input logic sw);
    logic [ENTRY_W-1:0] e;
    e = '0;
    e[E_BIT0] = ~nxt[0];
    e[E_BIT2] = ~nxt[2];
    e[E_BIT1] = sw ? cur[3] : cur[1];
    e[E_BIT3] = sw ? cur[1] : cur[3];
    e[E_SWAP] = sw;
    return e;
  endfunction

  for (genvar i = 0; i < TABLE_DEPTH; i++) begin : g_tab
    assign coded_table[i*ENTRY_W +: ENTRY_W] =
      encode(ref_table[i*DATA_W +: DATA_W],
             ref_table[((i + 1) % TABLE_DEPTH)*DATA_W +: DATA_W], swap_mask[i]);
  end
  assign table_ok = ($countones(swap_mask) == SWAP_COUNT);

  // Requests; a pending rewrite after a watchdog reset goes out alone
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lnk.exchange_request <= 1'b0;
      lnk.param_write_request <= 1'b0;
      lnk.exch_data <= PORT_INACTIVE;
      lnk.param_data <= PORT_INACTIVE;
      last_param <= PORT_INACTIVE;
    end else if (rewrite_pending && gap_cnt == 4'(REWRITE_GAP_CYCLES)) begin
      lnk.exchange_request <= 1'b0;
      lnk.param_write_request <= 1'b1;
      lnk.param_data <= last_param;
    end else begin
      lnk.exchange_request <= cmd_exchange;
      lnk.param_write_request <= cmd_param;
      if (cmd_exchange) begin
        lnk.exch_data <= cmd_exch_data;
      end
      if (cmd_param) begin
        lnk.param_data <= cmd_param_data;
        last_param <= cmd_param_data;
      end
    end
  end

  // Both strobes low at the same time marks a watchdog reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      both_low_seen <= 1'b0;
      rewrite_pending <= 1'b0;
      gap_cnt <= '0;
    end else begin
      if (!lnk.data_strobe_n && !lnk.param_strobe_n) begin
        both_low_seen <= 1'b1;
      end else if (both_low_seen && lnk.data_strobe_n && lnk.param_strobe_n) begin
        both_low_seen <= 1'b0;
        rewrite_pending <= 1'b1;
        gap_cnt <= '0;
      end
      if (rewrite_pending) begin
        if (gap_cnt == 4'(REWRITE_GAP_CYCLES)) begin
          rewrite_pending <= 1'b0;
        end else begin
          gap_cnt <= gap_cnt + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reply_valid <= 1'b0;
      reply_data <= PORT_INACTIVE;
    end else begin
      reply_valid <= lnk.answer_valid;
      if (lnk.answer_valid) begin
        reply_data <= lnk.answer_data;
      end
    end
  end

  // Outside circuit: latest drive value reappears inverted after the delay
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      drive_snap <= 2'h0;
      loop_level <= 2'h3;
      dly_cnt <= '0;
    end else begin
      if ({lnk.safe_drive_b, lnk.safe_drive_a} != drive_snap) begin
        drive_snap <= {lnk.safe_drive_b, lnk.safe_drive_a};
        dly_cnt <= DW'(LOOP_DELAY);
      end else if (dly_cnt != '0) begin
        dly_cnt <= dly_cnt - 1'b1;
        if (dly_cnt == DW'(1)) begin
          loop_level <= ~drive_snap;
        end
      end
    end
  end

  // Open switch removes the offset level and the data
  assign lnk.safe_offset_a = switch_a;
  assign lnk.safe_offset_b = switch_b;
  assign lnk.safe_input_a = switch_a & loop_level[0];
  assign lnk.safe_input_b = switch_b & loop_level[1];
endmodule
`default_nettype wire

/* File: src/cws_if.sv */
// Link between the slave's supervision/safety logic and the bus master plus
// the outside safety circuit. One clock, driven by the surrounding system.
`timescale 1ns/100ps
`default_nettype none
interface cws_if;
  import cws_pkg::*;
  logic exchange_request;
  logic param_write_request;
  logic [DATA_W-1:0] exch_data;
  logic [DATA_W-1:0] param_data;
  logic answer_valid;
  logic [DATA_W-1:0] answer_data;
  logic data_strobe_n;
  logic param_strobe_n;
  logic safe_drive_a;
  logic safe_drive_b;
  logic safe_input_a;
  logic safe_input_b;
  logic safe_offset_a;
  logic safe_offset_b;

  modport dev (
    input exchange_request, param_write_request, exch_data, param_data,
    input safe_input_a, safe_input_b, safe_offset_a, safe_offset_b,
    output answer_valid, answer_data, data_strobe_n, param_strobe_n,
    output safe_drive_a, safe_drive_b
  );
  modport host (
    output exchange_request, param_write_request, exch_data, param_data,
    output safe_input_a, safe_input_b, safe_offset_a, safe_offset_b,
    input answer_valid, answer_data, data_strobe_n, param_strobe_n,
    input safe_drive_a, safe_drive_b
  );
endinterface
`default_nettype wire

/* File: src/cws_pkg.sv */
// Constants and types shared by both ends of the supervision and safety code link.
// Assumes a single 25 MHz system clock on both ends.
package cws_pkg;
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DATA_W = 4;
  localparam int unsigned ADDR_W = 5;

  // Gap timeout: least time, rounded up
  localparam int unsigned MON_TIMEOUT_NS = 94_200_000;
  localparam int unsigned MON_TIMEOUT_CYCLES =
    (MON_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Code word hold after an exchange: least time, rounded up
  localparam int unsigned HOLD_NS = 224_000;
  localparam int unsigned HOLD_CYCLES = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Strobe low time on the port pins
  localparam int unsigned STROBE_NS = 1_000;
  localparam int unsigned STROBE_CYCLES = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Loop delay of the outside safety circuit: longest time, rounded down
  localparam int unsigned SAFE_DELAY_NS = 20_000;
  localparam int unsigned SAFE_DELAY_CYCLES = SAFE_DELAY_NS / CLK_PERIOD_NS;
  // Pause between end of forced strobes and the master's parameter rewrite
  localparam int unsigned REWRITE_GAP_CYCLES = 8;

  // Code table layout: one 5-bit entry per position
  localparam int unsigned TABLE_DEPTH = 8;
  localparam int unsigned IDX_W = 3;
  localparam int unsigned ENTRY_W = 5;
  localparam int unsigned E_BIT0 = 0;
  localparam int unsigned E_BIT1 = 1;
  localparam int unsigned E_BIT2 = 2;
  localparam int unsigned E_BIT3 = 3;
  localparam int unsigned E_SWAP = 4;
  localparam int unsigned SWAP_COUNT = 4;

  // Values after reset and init
  localparam logic [3:0] PORT_INACTIVE = 4'h0;

  typedef enum logic [1:0] {WD_IDLE, WD_STROBE, WD_RESET, WD_INIT} cws_wd_state_t;
endpackage

/* File: tb/cws_link_properties.sv */
// Checker on the link between both ends: answer, strobe and watchdog timing.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module cws_link_checker
  import cws_pkg::*;
#(
  parameter int unsigned MON_CYCLES = 200,
  parameter int unsigned STB_CYCLES = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Link
  input wire logic exchange_request,
  input wire logic param_write_request,
  input wire logic [DATA_W-1:0] param_data,
  input wire logic answer_valid,
  input wire logic [DATA_W-1:0] answer_data,
  input wire logic data_strobe_n,
  input wire logic param_strobe_n
);
  int unsigned dlow;
  int unsigned plow;
  int unsigned gap;
  logic forced;
  logic dis;
  logic both_low;
  assign both_low = !data_strobe_n && !param_strobe_n;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    dlow <= (rst || data_strobe_n) ? 0 : dlow + 1;
    plow <= (rst || param_strobe_n) ? 0 : plow + 1;
  end
  // Saturates so a long idle spell cannot wrap
  always_ff @(posedge sys_clk) begin
    if (rst || exchange_request || param_write_request) begin
      gap <= 0;
    end else if (gap < MON_CYCLES + 8) begin
      gap <= gap + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      forced <= 1'h0;
    end else if ($fell(data_strobe_n) && $fell(param_strobe_n)) begin
      forced <= 1'h1;
    end else if (data_strobe_n) begin
      forced <= 1'h0;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || param_write_request) begin
      dis <= 1'h0;
    end else if (forced && data_strobe_n) begin
      dis <= 1'h1;
    end
  end
  property p_exch_answer;
    exchange_request && !dis && !forced && !both_low |=> answer_valid && !data_strobe_n;
  endproperty
  a_exch_answer: assert property (p_exch_answer)
    else $error("exchange not answered");
  property p_param_echo;
    param_write_request && !forced && !both_low |=> answer_valid && answer_data == $past(param_data);
  endproperty
  a_param_echo: assert property (p_param_echo)
    else $error("parameter write not echoed");
  property p_answer_cause;
    answer_valid |-> $past(exchange_request) || $past(param_write_request);
  endproperty
  a_answer_cause: assert property (p_answer_cause)
    else $error("answer without request");
  property p_dstb_cause;
    $fell(data_strobe_n) |-> $past(exchange_request) || $fell(param_strobe_n);
  endproperty
  a_dstb_cause: assert property (p_dstb_cause)
    else $error("data strobe without cause");
  property p_dstb_width;
    $rose(data_strobe_n) |-> dlow == STB_CYCLES;
  endproperty
  a_dstb_width: assert property (p_dstb_width)
    else $error("data strobe width wrong");
  property p_pstb_width;
    $rose(param_strobe_n) |-> plow == STB_CYCLES;
  endproperty
  a_pstb_width: assert property (p_pstb_width)
    else $error("parameter strobe width wrong");
  property p_forced_together;
    forced && $rose(data_strobe_n) |-> $rose(param_strobe_n);
  endproperty
  a_forced_together: assert property (p_forced_together)
    else $error("forced strobes not ending together");
  property p_refused;
    exchange_request && dis |=> !answer_valid ##1 data_strobe_n;
  endproperty
  a_refused: assert property (p_refused)
    else $error("exchange served while disabled");
  property p_wd_gap;
    $fell(data_strobe_n) && $fell(param_strobe_n) |-> gap >= MON_CYCLES;
  endproperty
  a_wd_gap: assert property (p_wd_gap)
    else $error("watchdog fired early");
  c_forced: cover property ($fell(data_strobe_n) && $fell(param_strobe_n));
  c_refused: cover property (exchange_request && dis);
  c_param: cover property (param_write_request ##1 answer_valid);
endmodule
`default_nettype wire

/* File: tb/tb_comm_watchdog_safety_code.sv */
// Bench: both link ends joined, driven from the master command side.
// Assumes shortened timeouts so every interval fits a quick run.
`timescale 1ns/100ps
`default_nettype none
module tb_comm_watchdog_safety_code;
  import cws_pkg::*;
  localparam int unsigned MON = 200;
  // Stored table expected from the reference table below
  localparam logic [39:0] CODED = {5'h06, 5'h12, 5'h1B, 5'h0E, 5'h09, 5'h1C, 5'h01, 5'h10};
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  logic lock, inh, p0f, saf, sop, nvm, adel, cx, cp, sw_a, sw_b, rv, tok, ok;
  logic red, xdis, wde, sact, dme, sye, exe;
  logic [2:0] req3;
  logic [4:0] addr, e, pv;
  logic [3:0] ped, ced, cpd, rd, dp, pp, want;
  logic [31:0] reft;
  logic [7:0] swm;
  logic [39:0] ctab;
  int bad_count = 0;
  int compares = 0;
  int n;
  cws_if lnk();
  cws_host #(.LOOP_DELAY(5)) cws_host_i (.sys_clk(sys_clk), .rst(rst), .lnk(lnk),
    .cmd_exchange(cx), .cmd_param(cp), .cmd_exch_data(ced), .cmd_param_data(cpd),
    .reply_data(rd), .reply_valid(rv), .switch_a(sw_a), .switch_b(sw_b),
    .ref_table(reft), .swap_mask(swm), .coded_table(ctab), .table_ok(tok));
  cws_dev #(.MON_CYCLES(MON), .HOLD_CYC(20), .STB_CYCLES(3)) cws_dev_i (.sys_clk(sys_clk),
    .rst(rst), .lnk(lnk), .program_lock_flag(lock), .inhibit_flag(inh),
    .param_bit_wd_enable_flag(p0f), .safety_enable(saf), .safe_on_param(sop),
    .slave_address(addr), .nvm_write_busy(nvm), .address_delete(adel), .code_table(ctab),
    .delay_mode_req(req3[0]), .sync_io_req(req3[1]), .ext_4io_req(req3[2]),
    .delay_mode_en(dme), .sync_io_en(sye), .ext_4io_en(exe), .port_inputs(ped),
    .data_port(dp), .param_port(pp), .red_status_indicator(red), .exchange_disable(xdis),
    .watchdog_enable(wde), .safety_active(sact));
  cws_link_checker #(.MON_CYCLES(MON), .STB_CYCLES(3)) cws_link_checker_i (
    .sys_clk(sys_clk), .rst(rst), .exchange_request(lnk.exchange_request),
    .param_write_request(lnk.param_write_request), .param_data(lnk.param_data),
    .answer_valid(lnk.answer_valid), .answer_data(lnk.answer_data),
    .data_strobe_n(lnk.data_strobe_n), .param_strobe_n(lnk.param_strobe_n));
  always #20 sys_clk = ~sys_clk;
  task chk(input logic [3:0] got, input logic [3:0] want_v, input logic [3:0] m);
    compares++;
    if ((got & m) !== (want_v & m)) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got & m, want_v & m);
    end
  endtask
  // Outputs are sampled on the falling edge, clear of register updates
  task xfer(input logic par, input logic [3:0] d, input int lim, output logic got);
    int i;
    @(posedge sys_clk);
    if (par) begin
      cp <= 1'h1;
      cpd <= d;
    end else begin
      cx <= 1'h1;
      ced <= d;
    end
    @(posedge sys_clk);
    cp <= 1'h0;
    cx <= 1'h0;
    got = 1'h0;
    for (i = 0; i < lim && !got; i++) begin
      @(negedge sys_clk);
      got = (rv === 1'h1);
    end
  endtask
  task test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    $display("unexpected at %0t: run hung", $time);
    test_done();
  end
  initial begin
    {lock, inh, p0f, saf, sop, nvm, adel, cx, cp} = 9'h000;
    {sw_a, sw_b, req3, addr, ped, ced, cpd} = {2'h3, 3'h7, 5'h05, 12'h000};
    reft = 32'h7CBE9651;
    swm = 8'h65;
    repeat (20) @(posedge sys_clk);
    rst <= 1'h0;
    @(negedge sys_clk);
    chk({red, xdis, 2'h0}, 4'h0, 4'hC);
    chk(dp | pp, 4'h0, 4'hF);
    $display("test reset done");
    for (int r = 0; r < 2; r++) begin
      xfer(1'h1, {3'h0, r[0]}, 8, ok);
      for (int c = 0; c < 16; c++) begin
        @(posedge sys_clk);
        {lock, inh, p0f, saf} <= c[3:0];
        ped <= {4{~r[0]}};
        req3 <= c[3:1];
        @(negedge sys_clk);
        chk({3'h0, wde}, {3'h0, lock & ~inh & (~p0f | saf | r[0])}, 4'h1);
        chk({sact, dme, sye, exe}, {saf, {req3[0], req3[1], req3[2]} & {3{~saf}}}, 4'hF);
      end
    end
    $display("test enable table done");
    @(posedge sys_clk);
    {lock, inh, p0f, saf} <= 4'h0;
    ped <= 4'hA;
    xfer(1'h0, 4'h5, 8, ok);
    chk(rd, 4'hA, 4'hF);
    xfer(1'h1, 4'h3, 8, ok);
    chk(pp, 4'h3, 4'hF);
    repeat (MON - 10) @(negedge sys_clk);
    chk({3'h0, red}, 4'h0, 4'h1);
    repeat (20) @(negedge sys_clk);
    chk({3'h0, red}, 4'h1, 4'h1);
    xfer(1'h0, 4'h5, 8, ok);
    @(negedge sys_clk);
    chk({3'h0, red}, 4'h0, 4'h1);
    @(posedge sys_clk);
    adel <= 1'h1;
    @(posedge sys_clk);
    adel <= 1'h0;
    addr <= 5'h00;
    xfer(1'h1, 4'h3, 8, ok);
    repeat (MON + 20) @(negedge sys_clk);
    chk({3'h0, red}, 4'h0, 4'h1);
    $display("test monitor done");
    @(posedge sys_clk);
    {lock, nvm} <= 2'h3;
    addr <= 5'h05;
    xfer(1'h1, 4'h9, 8, ok);
    xfer(1'h0, 4'h6, 8, ok);
    repeat (MON + 20) @(negedge sys_clk);
    chk({xdis, 1'h0, lnk.data_strobe_n, lnk.param_strobe_n}, 4'h3, 4'hB);
    @(posedge sys_clk);
    nvm <= 1'h0;
    for (n = 0; n < 10 && lnk.data_strobe_n !== 1'h0; n++) @(negedge sys_clk);
    chk({dp[1:0], lnk.data_strobe_n, lnk.param_strobe_n}, 4'h8, 4'hF);
    chk(pp, 4'h9, 4'hF);
    for (n = 0; n < 10 && lnk.data_strobe_n !== 1'h1; n++) @(negedge sys_clk);
    xfer(1'h0, 4'h1, 4, ok);
    chk({ok, xdis, 2'h0}, 4'h4, 4'hC);
    chk(dp | pp, 4'h0, 4'hF);
    for (n = 0; n < 30 && xdis !== 1'h0; n++) @(negedge sys_clk);
    @(negedge sys_clk);
    chk(pp, 4'h9, 4'hF);
    xfer(1'h0, 4'h2, 8, ok);
    chk({3'h0, ok}, 4'h1, 4'h1);
    $display("test watchdog done");
    @(posedge sys_clk);
    {lock, saf, rst} <= 3'h3;
    repeat (2) @(posedge sys_clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      chk(ctab[5*i+:4], CODED[5*i+:4], 4'hF);
      chk({3'h0, ctab[5*i+4]}, {3'h0, CODED[5*i+4]}, 4'h1);
    end
    chk({3'h0, tok}, 4'h1, 4'h1);
    repeat (30) @(negedge sys_clk);
    for (int k = 1; k < 12; k++) begin
      e = CODED[5*(k%8)+:5];
      pv = CODED[5*((k-1)%8)+:5];
      @(posedge sys_clk);
      // Open switches force their looped bits low, so only bits 1 and 3 count
      {sw_a, sw_b} <= (k == 10) ? 2'h1 : (k == 11) ? 2'h2 : 2'h3;
      sop <= (k > 5);
      xfer(1'h0, 4'h0, 8, ok);
      want = {sw_b & (e[4] ? e[1] : e[3]), ~pv[2], sw_a & (e[4] ? e[3] : e[1]), ~pv[0]};
      chk(rd, want, (k > 9) ? 4'hA : 4'hF);
      if (k == 3) begin
        xfer(1'h0, 4'h0, 8, ok);
        chk(rd, want, 4'hA);
      end
      @(negedge sys_clk);
      chk({2'h0, lnk.safe_drive_b, lnk.safe_drive_a}, {2'h0, e[2], e[0]}, 4'h3);
      chk(sop ? pp : dp, {e[2], 1'h0, e[0], 1'h0}, 4'hF);
      repeat (40) @(negedge sys_clk);
    end
    $display("test safety done");
    test_done();
  end
endmodule
`default_nettype wire
